// ---- src/eips_top.sv ----
// top of the external interrupt pin selector for channels 2 to 7
// ----------------------------------------
// ----------------------------------------
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module eips_top
  import eips_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // register port
  input wire logic [EIPS_ADDR_W-1:0] addr_i,
  input wire logic [EIPS_DATA_W-1:0] wr_data_i,
  input wire logic [1:0] byte_en_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [EIPS_DATA_W-1:0] rd_data_o,
  // port pins
  input wire logic [EIPS_GRP0_PINS-1:0] port0_i,
  input wire logic [EIPS_GRP1_PINS-1:0] crystal_pin_i,
  input wire logic [EIPS_GRP2_PINS-1:0] port2_i,
  input wire logic [EIPS_GRP_FULL_PINS-1:0] port3_i,
  input wire logic [EIPS_GRP_FULL_PINS-1:0] port4_i,
  input wire logic [EIPS_GRP_FULL_PINS-1:0] port5_i,
  // channel levels to the edge detectors
  output logic irq_channel_2_o,
  output logic irq_channel_3_o,
  output logic irq_channel_4_o,
  output logic irq_channel_5_o,
  output logic irq_channel_6_o,
  output logic irq_channel_7_o
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic hit23;
  logic hit45;
  logic hit67;
  logic [15:0] pair23_pin_select;
  logic [15:0] pair45_pin_select;
  logic [15:0] pair67_pin_select;
  logic [15:0] nxt_pair23;
  logic [15:0] nxt_pair45;
  logic [15:0] nxt_pair67;

  assign hit23 = (addr_i == EIPS_PAIR23_ADDR);
  assign hit45 = (addr_i == EIPS_PAIR45_ADDR);
  assign hit67 = (addr_i == EIPS_PAIR67_ADDR);

  // ----------------------------------------
  // selection registers
  // ----------------------------------------
  // byte lanes give the 8-bit and 16-bit access sizes
  eips_sel_reg u_pair23 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .wr_i(wr_en_i && hit23),
    .byte_en_i(byte_en_i),
    .wr_data_i(wr_data_i),
    .value_o(pair23_pin_select),
    .nxt_value_o(nxt_pair23)
  );

  eips_sel_reg u_pair45 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .wr_i(wr_en_i && hit45),
    .byte_en_i(byte_en_i),
    .wr_data_i(wr_data_i),
    .value_o(pair45_pin_select),
    .nxt_value_o(nxt_pair45)
  );

  eips_sel_reg u_pair67 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .wr_i(wr_en_i && hit67),
    .byte_en_i(byte_en_i),
    .wr_data_i(wr_data_i),
    .value_o(pair67_pin_select),
    .nxt_value_o(nxt_pair67)
  );

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (en_i) begin
      nxt_rd_data = EIPS_UNMAPPED_DATA;
      if (rd_en_i) begin
        if (hit23) begin
          nxt_rd_data = pair23_pin_select;
        end else if (hit45) begin
          nxt_rd_data = pair45_pin_select;
        end else if (hit67) begin
          nxt_rd_data = pair67_pin_select;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_ff <= EIPS_UNMAPPED_DATA;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_o = rd_data_ff;

  // ----------------------------------------
  // pin routing
  // ----------------------------------------
  logic [EIPS_FLAT_W-1:0] flat_pins;
  logic [7:0] chan_sel [6];
  logic [5:0] chan_level;
  logic [5:0] irq_ff;
  logic [5:0] nxt_irq;

  // unused slots of short groups stay low so a prohibited code cannot pick noise
  assign flat_pins = {port5_i, port4_i, port3_i, 4'h0, port2_i, 6'h00, crystal_pin_i, 2'h0, port0_i};

  // next selection is used so the source switches with the write itself
  assign chan_sel[0] = nxt_pair23[7:0];
  assign chan_sel[1] = nxt_pair23[15:EIPS_ODD_LSB];
  assign chan_sel[2] = nxt_pair45[7:0];
  assign chan_sel[3] = nxt_pair45[15:EIPS_ODD_LSB];
  assign chan_sel[4] = nxt_pair67[7:0];
  assign chan_sel[5] = nxt_pair67[15:EIPS_ODD_LSB];

  for (genvar ch = 0; ch < 6; ch++) begin : g_mux
    // group nibble and bit nibble decode to one pin
    eips_pin_mux u_mux (
      .pins_i(flat_pins),
      .sel_i(chan_sel[ch]),
      .level_o(chan_level[ch])
    );
  end

  always_comb begin
    nxt_irq = irq_ff;
    if (en_i) begin
      nxt_irq = chan_level;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ff <= 6'h00;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_channel_2_o = irq_ff[0];
  assign irq_channel_3_o = irq_ff[1];
  assign irq_channel_4_o = irq_ff[2];
  assign irq_channel_5_o = irq_ff[3];
  assign irq_channel_6_o = irq_ff[4];
  assign irq_channel_7_o = irq_ff[5];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic wrote_ff;
  logic nxt_wrote;

  always_comb begin
    nxt_wrote = wrote_ff || (en_i && wr_en_i);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wrote_ff <= 1'b0;
    end else begin
      wrote_ff <= nxt_wrote;
    end
  end

  chk_pair23_word: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && wr_en_i && addr_i == EIPS_PAIR23_ADDR && byte_en_i == 2'h3
    |=> pair23_pin_select == $past(wr_data_i))
    else $error("pair23 word write not stored");

  chk_pair45_word: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && wr_en_i && addr_i == EIPS_PAIR45_ADDR && byte_en_i == 2'h3
    |=> pair45_pin_select == $past(wr_data_i) ##1 pair45_pin_select == $past(wr_data_i, 2) || $past(wr_en_i))
    else $error("pair45 word write not stored");

  chk_pair67_word: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && wr_en_i && addr_i == EIPS_PAIR67_ADDR && byte_en_i == 2'h3
    |=> pair67_pin_select == $past(wr_data_i) && pair23_pin_select == $past(pair23_pin_select))
    else $error("pair67 word write wrong");

  chk_ch2_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i |=> irq_channel_2_o == eips_route($past(flat_pins), pair23_pin_select[7:0]))
    else $error("channel 2 level does not follow its selector");

  chk_ch4_group: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && nxt_pair45[7:4] == 4'h3 && nxt_pair45[3:0] == 4'h7 |=> irq_channel_4_o == $past(port3_i[7]))
    else $error("channel 4 group nibble misrouted");

  chk_ch3_odd: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i |=> irq_channel_3_o == eips_route($past(flat_pins), pair23_pin_select[15:8]))
    else $error("channel 3 level does not follow high byte");

  chk_example_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && nxt_pair67[15:8] == 8'h51 |=> irq_channel_7_o == $past(port5_i[1]))
    else $error("group 5 pin 1 not routed to channel 7");

  chk_reset_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !wrote_ff |-> pair23_pin_select == 16'h0000 && pair45_pin_select == 16'h0000 && pair67_pin_select == 16'h0000)
    else $error("selection not zero before first write");

  chk_byte_lane: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && wr_en_i && hit45 && byte_en_i == 2'h2
    |=> pair45_pin_select[7:0] == $past(pair45_pin_select[7:0]) && pair45_pin_select[15:8] == $past(wr_data_i[15:8]))
    else $error("high byte write disturbed low byte");

  chk_read_back: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && rd_en_i && hit67 |=> rd_data_o == $past(pair67_pin_select)
    ##1 (rd_data_o == 16'h0000 || $past(rd_en_i) || !$past(en_i)))
    else $error("read data wrong or held too long");

  chk_switch_now: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && wr_en_i && hit67 && byte_en_i[0]
    |=> irq_channel_6_o == eips_route($past(flat_pins), $past(wr_data_i[7:0])))
    else $error("channel 6 did not switch with the write");

  chk_freeze: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !en_i |=> $stable(irq_ff) && $stable(pair23_pin_select) && $stable(rd_data_o))
    else $error("state moved while enable low");

  chk_ch4_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i
    |=> irq_channel_4_o == eips_route($past(flat_pins), pair45_pin_select[7:0]))
    else $error("channel 4 level does not follow its selector");

  chk_ch5_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i
    |=> irq_channel_5_o == eips_route($past(flat_pins), pair45_pin_select[15:8]))
    else $error("channel 5 level does not follow high byte");

  chk_ch6_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i
    |=> irq_channel_6_o == eips_route($past(flat_pins), pair67_pin_select[7:0]))
    else $error("channel 6 level does not follow its selector");

  chk_ch7_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i
    |=> irq_channel_7_o == eips_route($past(flat_pins), pair67_pin_select[15:8]))
    else $error("channel 7 level does not follow high byte");

  // prohibited codes must read low so a stray selection cannot raise a request
  chk_group_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && nxt_pair23[7:4] > 4'h5
    |=> !irq_channel_2_o)
    else $error("channel 2 not low for a missing group");

  chk_pin_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && nxt_pair23[7:4] == 4'h0 && nxt_pair23[3:0] > 4'h5
    |=> !irq_channel_2_o)
    else $error("channel 2 not low for a missing pin");

  chk_crystal_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && nxt_pair45[15:8] == 8'h11
    |=> irq_channel_5_o == $past(crystal_pin_i[1]))
    else $error("crystal pin 1 not routed to channel 5");

  chk_low_lane: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && wr_en_i && hit23 && byte_en_i == 2'h1
    |=> pair23_pin_select[15:8] == $past(pair23_pin_select[15:8]) && pair23_pin_select[7:0] == $past(wr_data_i[7:0]))
    else $error("low byte write disturbed high byte");

  chk_miss_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && wr_en_i && !hit23
    |=> pair23_pin_select == $past(pair23_pin_select))
    else $error("pair23 changed by a write elsewhere");

  chk_read_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    en_i && !rd_en_i
    |=> rd_data_o == EIPS_UNMAPPED_DATA)
    else $error("read data present without a read");

endmodule

// ---- src/eips_pkg.sv ----
// package: constants and helpers for the external interrupt pin selector
package eips_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int EIPS_ADDR_W = 16;
  localparam int EIPS_DATA_W = 16;
  localparam logic [15:0] EIPS_PAIR23_ADDR = 16'hF04A;
  localparam logic [15:0] EIPS_PAIR45_ADDR = 16'hF04C;
  localparam logic [15:0] EIPS_PAIR67_ADDR = 16'hF04E;
  localparam logic [15:0] EIPS_SEL_RESET = 16'h0000;
  localparam logic [15:0] EIPS_UNMAPPED_DATA = 16'h0000;

  // ----------------------------------------
  // field layout of one 8-bit selector
  // ----------------------------------------
  localparam int EIPS_INDEX_LSB = 0;
  localparam int EIPS_GROUP_LSB = 4;
  localparam int EIPS_FIELD_W = 4;
  localparam int EIPS_ODD_LSB = 8;

  // ----------------------------------------
  // port groups: pins per group, flat vector has 8 slots per group
  // ----------------------------------------
  localparam int EIPS_GROUPS = 6;
  localparam int EIPS_SLOTS = 8;
  localparam int EIPS_FLAT_W = EIPS_GROUPS * EIPS_SLOTS;
  localparam int EIPS_GRP0_PINS = 6;
  localparam int EIPS_GRP1_PINS = 2;
  localparam int EIPS_GRP2_PINS = 4;
  localparam int EIPS_GRP_FULL_PINS = 8;

  function automatic logic [3:0] eips_pin_count(input logic [3:0] group);
    case (group)
      4'h0: eips_pin_count = 4'(EIPS_GRP0_PINS);
      4'h1: eips_pin_count = 4'(EIPS_GRP1_PINS);
      4'h2: eips_pin_count = 4'(EIPS_GRP2_PINS);
      4'h3, 4'h4, 4'h5: eips_pin_count = 4'(EIPS_GRP_FULL_PINS);
      default: eips_pin_count = 4'h0;
    endcase
  endfunction

  // level of the pin a selector names; prohibited codes read as low
  function automatic logic eips_route(input logic [EIPS_FLAT_W-1:0] flat, input logic [7:0] sel);
    logic [3:0] grp;
    logic [3:0] idx;
    logic [5:0] pos;
    grp = sel[EIPS_GROUP_LSB +: EIPS_FIELD_W];
    idx = sel[EIPS_INDEX_LSB +: EIPS_FIELD_W];
    pos = {grp[2:0], idx[2:0]};
    if (idx < eips_pin_count(grp)) begin
      eips_route = flat[pos];
    end else begin
      eips_route = 1'b0;
    end
  endfunction

endpackage

// ---- src/eips_sel_reg.sv ----
// one 16-bit selection register with byte-lane writes
`timescale 1ns/1ns
module eips_sel_reg
  import eips_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // write side
  input wire logic wr_i,
  input wire logic [1:0] byte_en_i,
  input wire logic [15:0] wr_data_i,
  // value
  output logic [15:0] value_o,
  output logic [15:0] nxt_value_o
);

  logic [15:0] value_ff;
  logic [15:0] nxt_value;

  always_comb begin
    nxt_value = value_ff;
    if (en_i && wr_i) begin
      if (byte_en_i[0]) begin
        nxt_value[7:0] = wr_data_i[7:0];
      end
      if (byte_en_i[1]) begin
        nxt_value[15:8] = wr_data_i[15:8];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_ff <= EIPS_SEL_RESET;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value_o = value_ff;
  assign nxt_value_o = nxt_value;

endmodule

// ---- src/eips_pin_mux.sv ----
// one channel's source mux: group and bit nibbles pick a port pin
`timescale 1ns/1ns
module eips_pin_mux
  import eips_pkg::*;
(
  // pins and selector
  input wire logic [EIPS_FLAT_W-1:0] pins_i,
  input wire logic [7:0] sel_i,
  // chosen level
  output logic level_o
);

  always_comb begin
    level_o = eips_route(pins_i, sel_i);
  end

endmodule

// ---- verification/eips_pin_model.sv ----
// far-side model: port pins driven from one flat level pattern
`timescale 1ns/1ns
module eips_pin_model
  import eips_pkg::*;
(
  // pattern from the bench, 8 slots per group
  input wire logic [EIPS_FLAT_W-1:0] pattern_i,
  // port pins
  output logic [EIPS_GRP0_PINS-1:0] port0_o,
  output logic [EIPS_GRP1_PINS-1:0] crystal_pin_o,
  output logic [EIPS_GRP2_PINS-1:0] port2_o,
  output logic [EIPS_GRP_FULL_PINS-1:0] port3_o,
  output logic [EIPS_GRP_FULL_PINS-1:0] port4_o,
  output logic [EIPS_GRP_FULL_PINS-1:0] port5_o
);
  // group g pin b sits in slot g*8+b; slots past a group's pin count reach no pin
  assign port0_o = pattern_i[0 +: EIPS_GRP0_PINS];
  assign crystal_pin_o = pattern_i[8 +: EIPS_GRP1_PINS];
  assign port2_o = pattern_i[16 +: EIPS_GRP2_PINS];
  assign port3_o = pattern_i[24 +: EIPS_GRP_FULL_PINS];
  assign port4_o = pattern_i[32 +: EIPS_GRP_FULL_PINS];
  assign port5_o = pattern_i[40 +: EIPS_GRP_FULL_PINS];
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the external interrupt pin selector
`timescale 1ns/1ns
module tb;
  import eips_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wr_data_i = 16'h0000;
  logic [1:0] byte_en_i = 2'h3;
  logic [47:0] pat = 48'h0;
  logic [15:0] rd_data_o;
  logic [5:0] irq;
  logic [5:0] irq_q = 6'h00;
  logic [5:0] chan_on = 6'h00;
  logic [5:0] pend = 6'h00;
  logic pend_clr = 1'b0;
  logic [5:0] p0;
  logic [1:0] p1;
  logic [3:0] p2;
  logic [7:0] p3, p4, p5;
  int fail_count = 0;
  int num_checks = 0;
  logic [15:0] adr [3] = '{EIPS_PAIR23_ADDR, EIPS_PAIR45_ADDR, EIPS_PAIR67_ADDR};
  logic [15:0] vals [3] = '{16'h5123, 16'h3745, 16'h2011};
  // legal picks plus two prohibited ones
  logic [7:0] sels [8] = '{8'h51, 8'h05, 8'h11, 8'h23, 8'h37, 8'h40, 8'h06, 8'h60};
  localparam logic [47:0] PAT = 48'hA5C3_96E1_7B2D;

  eips_pin_model u_eips_pin_model (.pattern_i(pat), .port0_o(p0), .crystal_pin_o(p1), .port2_o(p2),
    .port3_o(p3), .port4_o(p4), .port5_o(p5));
  eips_top u_eips_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .en_i(en_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .byte_en_i(byte_en_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .port0_i(p0), .crystal_pin_i(p1), .port2_i(p2), .port3_i(p3),
    .port4_i(p4), .port5_i(p5), .irq_channel_2_o(irq[0]), .irq_channel_3_o(irq[1]),
    .irq_channel_4_o(irq[2]), .irq_channel_5_o(irq[3]), .irq_channel_6_o(irq[4]),
    .irq_channel_7_o(irq[5]));

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  // stand-in for the edge detectors downstream: a level change on an enabled channel is a request
  always @(posedge clock_i) begin
    irq_q <= irq;
    pend <= pend_clr ? 6'h00 : (pend | (chan_on & (irq ^ irq_q)));
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    byte_en_i <= be;
    wr_en_i <= 1'b1;
    @(posedge clock_i);
    wr_en_i <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe, so it is sampled there
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clock_i);
    rd_en_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  function automatic logic exp_lvl(input logic [47:0] p, input logic [7:0] sel);
    logic [3:0] g;
    logic [3:0] n;
    g = sel[7:4];
    n = (g == 4'h0) ? 4'h6 : (g == 4'h1) ? 4'h2 : (g == 4'h2) ? 4'h4 : (g <= 4'h5) ? 4'h8 : 4'h0;
    exp_lvl = (sel[3:0] < n) ? p[{g[2:0], sel[2:0]}] : 1'b0;
  endfunction

  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [15:0] d;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(adr[i], d);
      check(d, EIPS_SEL_RESET);
    end
    $display("test reset values done");
    for (int i = 0; i < 3; i++) wr(adr[i], vals[i], 2'h3);
    for (int i = 0; i < 3; i++) begin
      rd(adr[i], d);
      check(d, vals[i]);
    end
    @(posedge clock_i);
    #1;
    check(rd_data_o, 16'h0000);
    wr(adr[1], 16'hFF66, 2'h1);
    rd(adr[1], d);
    check(d, 16'h3766);
    $display("test word and byte access done");
    wr(16'hF04B, 16'hFFFF, 2'h3);
    wr(16'hF048, 16'hFFFF, 2'h3);
    rd(16'hF04D, d);
    check(d, EIPS_UNMAPPED_DATA);
    @(posedge clock_i);
    en_i <= 1'b0;
    wr(adr[0], 16'h0000, 2'h3);
    @(posedge clock_i);
    en_i <= 1'b1;
    rd(adr[0], d);
    check(d, vals[0]);
    $display("test unmapped and frozen access done");
    // each pick is checked with the pattern and its inverse so a stuck level shows
    for (int k = 0; k < 6; k++) begin
      for (int s = 0; s < 8; s++) begin
        @(posedge clock_i);
        pat <= PAT;
        chan_on <= 6'h00;
        wr(adr[k / 2], {sels[s], sels[s]}, (k % 2 == 1) ? 2'h2 : 2'h1);
        check({15'h0, irq[k]}, {15'h0, exp_lvl(PAT, sels[s])});
        pend_clr <= 1'b1;
        @(posedge clock_i);
        pat <= ~PAT;
        pend_clr <= 1'b0;
        chan_on[k] <= 1'b1;
        @(posedge clock_i);
        #1;
        check({15'h0, irq[k]}, {15'h0, exp_lvl(~PAT, sels[s])});
        @(posedge clock_i);
        #1;
        check({15'h0, pend[k]}, {15'h0, exp_lvl(PAT, sels[s]) ^ exp_lvl(~PAT, sels[s])});
      end
    end
    $display("test pin routing done");
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clock_i);
    fail_count++;
    test_done();
  end
endmodule
